// File: src/tscr_regs.vh
// Constants of the touch sensor configuration register bank.
// Assumes an 8-bit register port and a 125 MHz system clock.
`ifndef TSCR_REGS_VH
`define TSCR_REGS_VH

// Register offsets on the register port.
`define TSCR_OFF_FACTORY   8'h00
`define TSCR_OFF_OUTCTL    8'h02
`define TSCR_OFF_CALCTL0   8'h03
`define TSCR_OFF_CALCTL1   8'h04
`define TSCR_OFF_ACQ0      8'h05
`define TSCR_OFF_ACQ1      8'h06
`define TSCR_OFF_LOWPWR    8'h07
`define TSCR_FACTORY_VAL   8'hff

// Reset values of the stored fields.
`define TSCR_RST_OUTEN     4'h3
`define TSCR_RST_WAVE      2'h0
`define TSCR_RST_CAL       1'h0
`define TSCR_RST_SENSOR1_ENABLE      1'h1
`define TSCR_RST_ACQ       5'h00
`define TSCR_RST_SLEEP     5'h01
`define TSCR_RST_OSC       1'h1

// Field positions.
`define TSCR_WAVE_HI       7
`define TSCR_WAVE_LO       6
`define TSCR_CAL_BIT       1
`define TSCR_SENSOR1_ENABLE_BIT      0
`define TSCR_SLEEP_HI      5
`define TSCR_SLEEP_LO      1
`define TSCR_OSC_BIT       0

// Waveform codes.
`define TSCR_WAVE_NORMAL   2'b00
`define TSCR_WAVE_DOUBLE   2'b01
`define TSCR_WAVE_HALF     2'b10
`define TSCR_WAVE_RSVD     2'b11

// Sleep code ranges and interval bases.
`define TSCR_SLEEP_SEC     5'd10
`define TSCR_SLEEP_MAX     5'd18
`define TSCR_MS_PER_SEC    18'd1000

// Timing.
`define TSCR_CLK_PERIOD_NS 8
`define TSCR_PULSE_NS      1000000

`endif

// File: src/tscr_cal_seq.v
// Calibration sequencer for one sensor: sweeps the settling delay.
// Assumes the analogue core reports settled for the delay it is given.
`timescale 1ns/1ns
module tscr_cal_seq #(
  parameter SETTLE_CYCLES = 16
) (
  input  wire       clock,
  input  wire       srst,
  input  wire       request,
  input  wire       restart,
  input  wire       settled,
  output reg        busy,
  output reg        update,
  output reg        done,
  output reg  [4:0] delay
);
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_WAIT = 3'b010;
  localparam [2:0] ST_STEP = 3'b100;

  reg [2:0]  state;
  reg [15:0] waitCount;

  // ----------------------------------------------------------------
  // Sweep machine
  // ----------------------------------------------------------------
  // A dropped request abandons the sweep; a restart begins it again.
  always @(posedge clock) begin
    update <= 1'b0;
    done   <= 1'b0;
    if (srst || restart || !request) begin
      state     <= ST_IDLE;
      busy      <= 1'b0;
      delay     <= 5'h00;
      waitCount <= 16'h0000;
    end else begin
      case (state)
        ST_IDLE: begin
          busy      <= 1'b1;
          delay     <= 5'h00;
          update    <= 1'b1;
          waitCount <= 16'h0000;
          state     <= ST_WAIT;
        end
        ST_WAIT: begin
          waitCount <= waitCount + 16'h0001;
          if (waitCount == SETTLE_CYCLES[15:0] - 16'h0001) begin
            state <= ST_STEP;
          end
        end
        ST_STEP: begin
          waitCount <= 16'h0000;
          if (settled || delay == 5'h1f) begin
            busy  <= 1'b0;
            done  <= 1'b1;
            state <= ST_IDLE;
          end else begin
            delay  <= delay + 5'h01;
            update <= 1'b1;
            state  <= ST_WAIT;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // tscr_cal_seq

// File: src/tscr_sleep_timer.v
// Scan pacing: one scan per millisecond, or per sleep interval when idle.
// Assumes a one-cycle millisecond tick from the enclosing block.
`timescale 1ns/1ns
`include "tscr_regs.vh"
module tscr_sleep_timer (
  input  wire       clock,
  input  wire       srst,
  input  wire       msTick,
  input  wire       sleepOk,
  input  wire [4:0] sleepCode,
  output reg        scanStrobe
);
  reg [17:0] msCount;

  // Interval in milliseconds; codes 0 to 9 double from 1 ms, codes 10 to 18 double from 1000 ms.
  function [17:0] interval_ms;
    input [4:0] code;
    begin
      if (code < `TSCR_SLEEP_SEC) begin
        interval_ms = 18'd1 << code;
      end else if (code <= `TSCR_SLEEP_MAX) begin
        interval_ms = `TSCR_MS_PER_SEC << (code - `TSCR_SLEEP_SEC);
      end else begin
        interval_ms = 18'd1;
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // Interval counter
  // ----------------------------------------------------------------
  // Leaving sleep fires at the next tick so a detection is never delayed.
  always @(posedge clock) begin
    scanStrobe <= 1'b0;
    if (srst) begin
      msCount <= 18'h00000;
    end else if (msTick) begin
      if (!sleepOk || msCount + 18'd1 >= interval_ms(sleepCode)) begin
        msCount    <= 18'h00000;
        scanStrobe <= 1'b1;
      end else begin
        msCount <= msCount + 18'd1;
      end
    end
  end
endmodule // tscr_sleep_timer

// File: src/tscr_config_regs.v
// Configuration register bank of a dual-channel touch/proximity sensor.
// Assumes a byte register port decoded from the serial command layer and
// detection, settle and new-data signals from the analogue core.
//
// Notes on behaviour
// - Enabled detection conditions are ORed; the result alone sets the pin.
// - Pin goes low while any enabled button or proximity detection is true.
// - With all enables zero, pin pulses low 1 ms per new data.
// - Output control holds four enables at bits 3..0; bits 7..4 read zero.
// - Host clears calibrated bit 1 to request a new calibration.
// - Device sets the calibrated bit once that sensor's calibration ends.
// - Waveform field bits 7..6: 00 normal, 01 double, 10 half.
// - Reserved waveform code 11 acts as double.
// - Second sensor enable at bit 0; zero stops its scan and decode.
// - Settle delay field bits 4..0 is rewritten during recalibration.
// - Sleep field bits 5..1 doubles from 1 ms to 256 s.
// - Sleep codes 10011 to 11111 give 1 ms.
// - Sleep interval applies only while no detection is present.
// - Oscillator select bit 0: one is 32 MHz, zero is 16 MHz.
// - Idle after time-out without change; idle sleeps between readings.
// - Writing ff to location 00 restores defaults and recalibrates both.
`timescale 1ns/1ns
`include "tscr_regs.vh"
module tscr_config_regs #(
  parameter PULSE_CYCLES  = `TSCR_PULSE_NS / `TSCR_CLK_PERIOD_NS,
  parameter SETTLE_CYCLES = 16
) (
  input  wire        clock,
  input  wire        srst,
  input  wire        regWrite,
  input  wire        regRead,
  input  wire [7:0]  regAddr,
  input  wire [7:0]  regWrData,
  output reg  [7:0]  regRdData,
  input  wire [1:0]  buttonDetect,
  input  wire [1:0]  proxDetect,
  input  wire        newData,
  input  wire        envChange,
  input  wire [1:0]  calSettled,
  input  wire [15:0] idleTimeoutMs,
  output reg         detectOutN,
  output reg  [1:0]  waveform0,
  output reg  [1:0]  waveform1,
  output reg         sensor1Scan,
  output reg  [4:0]  settleDelay0,
  output reg  [4:0]  settleDelay1,
  output reg  [1:0]  calBusy,
  output reg         oscFast,
  output reg         idle,
  output wire        scanStrobe
);
  // ----------------------------------------------------------------
  // Stored fields
  // ----------------------------------------------------------------
  // Reserved bits are not stored; they read as zero.
  reg [3:0]  outEnable;
  reg [1:0]  waveSel0;
  reg [1:0]  waveSel1;
  reg [1:0]  calibrated;
  reg        sensor1Enable;
  reg [4:0]  acq0;
  reg [4:0]  acq1;
  reg [4:0]  sleepCode;
  reg        oscSelect;

  // Timers and the quiet-time count.
  reg [31:0] pulseCount;
  reg        pulseActive;
  reg [31:0] msPrescale;
  reg        msTick;
  reg [15:0] quietMs;

  // Internal strobes and decoded state.
  wire       factory;
  wire [1:0] seqBusy;
  wire [1:0] seqUpdate;
  wire [1:0] seqDone;
  wire [4:0] seqDelay0;
  wire [4:0] seqDelay1;
  wire [1:0] calRequest;
  wire [3:0] detectState;
  wire       anyEnabled;
  wire       anyDetect;

  // Effective waveform; the reserved code behaves as double.
  function [1:0] wave_eff;
    input [1:0] sel;
    begin
      if (sel == `TSCR_WAVE_RSVD) begin
        wave_eff = `TSCR_WAVE_DOUBLE;
      end else begin
        wave_eff = sel;
      end
    end
  endfunction

  // Write strobe for a given register offset.
  function wr_hit;
    input [7:0] off;
    begin
      wr_hit = regWrite && (regAddr == off);
    end
  endfunction

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  assign factory = regWrite && (regAddr == `TSCR_OFF_FACTORY) &&
                   (regWrData == `TSCR_FACTORY_VAL);

  // Output control, waveform, enable and low-power fields.
  always @(posedge clock) begin
    if (srst || factory) begin
      outEnable     <= `TSCR_RST_OUTEN;
      waveSel0      <= `TSCR_RST_WAVE;
      waveSel1      <= `TSCR_RST_WAVE;
      sensor1Enable <= `TSCR_RST_SENSOR1_ENABLE;
      sleepCode     <= `TSCR_RST_SLEEP;
      oscSelect     <= `TSCR_RST_OSC;
    end else if (wr_hit(`TSCR_OFF_OUTCTL)) begin
      outEnable <= regWrData[3:0];
    end else if (wr_hit(`TSCR_OFF_CALCTL0)) begin
      waveSel0 <= regWrData[`TSCR_WAVE_HI:`TSCR_WAVE_LO];
    end else if (wr_hit(`TSCR_OFF_CALCTL1)) begin
      waveSel1      <= regWrData[`TSCR_WAVE_HI:`TSCR_WAVE_LO];
      sensor1Enable <= regWrData[`TSCR_SENSOR1_ENABLE_BIT];
    end else if (wr_hit(`TSCR_OFF_LOWPWR)) begin
      sleepCode <= regWrData[`TSCR_SLEEP_HI:`TSCR_SLEEP_LO];
      oscSelect <= regWrData[`TSCR_OSC_BIT];
    end
  end

  // Calibrated flags. A finishing calibration wins over a host write in
  // the same cycle, so completion is never lost; the host re-requests.
  always @(posedge clock) begin
    if (srst || factory) begin
      calibrated <= {2{`TSCR_RST_CAL}};
    end else begin
      if (seqDone[0]) begin
        calibrated[0] <= 1'b1;
      end else if (wr_hit(`TSCR_OFF_CALCTL0)) begin
        calibrated[0] <= regWrData[`TSCR_CAL_BIT];
      end
      if (seqDone[1]) begin
        calibrated[1] <= 1'b1;
      end else if (wr_hit(`TSCR_OFF_CALCTL1)) begin
        calibrated[1] <= regWrData[`TSCR_CAL_BIT];
      end
    end
  end

  // Settle delays. The sweep wins a same-cycle write, so a host write during
  // calibration is overwritten at the next step unless that step ends the sweep.
  always @(posedge clock) begin
    if (srst || factory) begin
      acq0 <= `TSCR_RST_ACQ;
      acq1 <= `TSCR_RST_ACQ;
    end else begin
      if (seqUpdate[0]) begin
        acq0 <= seqDelay0;
      end else if (wr_hit(`TSCR_OFF_ACQ0)) begin
        acq0 <= regWrData[4:0];
      end
      if (seqUpdate[1]) begin
        acq1 <= seqDelay1;
      end else if (wr_hit(`TSCR_OFF_ACQ1)) begin
        acq1 <= regWrData[4:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // One cycle of latency; unmapped locations and reserved bits read zero.
  always @(posedge clock) begin
    if (srst) begin
      regRdData <= 8'h00;
    end else if (regRead) begin
      if (regAddr == `TSCR_OFF_OUTCTL) begin
        regRdData <= {4'h0, outEnable};
      end else if (regAddr == `TSCR_OFF_CALCTL0) begin
        regRdData <= {waveSel0, 4'h0, calibrated[0], 1'b0};
      end else if (regAddr == `TSCR_OFF_CALCTL1) begin
        regRdData <= {waveSel1, 4'h0, calibrated[1], sensor1Enable};
      end else if (regAddr == `TSCR_OFF_ACQ0) begin
        regRdData <= {3'h0, acq0};
      end else if (regAddr == `TSCR_OFF_ACQ1) begin
        regRdData <= {3'h0, acq1};
      end else if (regAddr == `TSCR_OFF_LOWPWR) begin
        regRdData <= {2'h0, sleepCode, oscSelect};
      end else begin
        regRdData <= 8'h00;
      end
    end
  end

  // ----------------------------------------------------------------
  // Calibration sequencers
  // ----------------------------------------------------------------
  // A cleared calibrated bit is a standing request; sensor 1 only asks
  // while it is enabled.
  // The done cycle masks it, so a finished sweep cannot restart.
  assign calRequest[0] = ~calibrated[0] & ~seqDone[0];
  assign calRequest[1] = ~calibrated[1] & ~seqDone[1] & sensor1Enable;

  tscr_cal_seq #(
    .SETTLE_CYCLES (SETTLE_CYCLES)
  ) u_cal0 (
    .clock   (clock),
    .srst    (srst),
    .request (calRequest[0]),
    .restart (factory),
    .settled (calSettled[0]),
    .busy    (seqBusy[0]),
    .update  (seqUpdate[0]),
    .done    (seqDone[0]),
    .delay   (seqDelay0)
  );

  tscr_cal_seq #(
    .SETTLE_CYCLES (SETTLE_CYCLES)
  ) u_cal1 (
    .clock   (clock),
    .srst    (srst),
    .request (calRequest[1]),
    .restart (factory),
    .settled (calSettled[1]),
    .busy    (seqBusy[1]),
    .update  (seqUpdate[1]),
    .done    (seqDone[1]),
    .delay   (seqDelay1)
  );

  // ----------------------------------------------------------------
  // Detect output pin
  // ----------------------------------------------------------------
  // Sensor 1 results are ignored while it is disabled.
  assign detectState = {proxDetect[1] & sensor1Enable, proxDetect[0],
                        buttonDetect[1] & sensor1Enable, buttonDetect[0]};
  assign anyEnabled  = |outEnable;
  assign anyDetect   = |detectState;

  // New-data pulse timer; only armed in interrupt mode.
  always @(posedge clock) begin
    if (srst || anyEnabled) begin
      pulseCount  <= 32'h00000000;
      pulseActive <= 1'b0;
    end else if (newData) begin
      pulseCount  <= 32'h00000000;
      pulseActive <= 1'b1;
    end else if (pulseActive) begin
      if (pulseCount == PULSE_CYCLES - 1) begin
        pulseActive <= 1'b0;
      end else begin
        pulseCount <= pulseCount + 32'h00000001;
      end
    end
  end

  // Pin level: OR of enabled states, else the pulse, else high.
  always @(posedge clock) begin
    if (srst) begin
      detectOutN <= 1'b1;
    end else if (anyEnabled) begin
      detectOutN <= ~|(detectState & outEnable);
    end else if (newData || pulseActive) begin
      detectOutN <= 1'b0;
    end else begin
      detectOutN <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Idle tracking and scan pacing
  // ----------------------------------------------------------------
  // Millisecond tick shares the pulse time base.
  always @(posedge clock) begin
    if (srst) begin
      msPrescale <= 32'h00000000;
      msTick     <= 1'b0;
    end else if (msPrescale == PULSE_CYCLES - 1) begin
      msPrescale <= 32'h00000000;
      msTick     <= 1'b1;
    end else begin
      msPrescale <= msPrescale + 32'h00000001;
      msTick     <= 1'b0;
    end
  end

  // Quiet time counts up while nothing changes; a detection or change
  // drops the block out of idle at once.
  always @(posedge clock) begin
    if (srst || envChange || anyDetect) begin
      quietMs <= 16'h0000;
      idle    <= 1'b0;
    end else if (quietMs >= idleTimeoutMs) begin
      idle <= 1'b1;
    end else if (msTick) begin
      quietMs <= quietMs + 16'h0001;
    end
  end

  // Scans pace at 1 ms until idle.
  tscr_sleep_timer u_sleep (
    .clock      (clock),
    .srst       (srst),
    .msTick     (msTick),
    .sleepOk    (idle),
    .sleepCode  (sleepCode),
    .scanStrobe (scanStrobe)
  );

  // ----------------------------------------------------------------
  // Registered configuration outputs
  // ----------------------------------------------------------------
  // Every output leaves from a flop.
  always @(posedge clock) begin
    if (srst) begin
      waveform0    <= `TSCR_WAVE_NORMAL;
      waveform1    <= `TSCR_WAVE_NORMAL;
      sensor1Scan  <= `TSCR_RST_SENSOR1_ENABLE;
      settleDelay0 <= `TSCR_RST_ACQ;
      settleDelay1 <= `TSCR_RST_ACQ;
      calBusy      <= 2'b00;
      oscFast      <= `TSCR_RST_OSC;
    end else begin
      waveform0    <= wave_eff(waveSel0);
      waveform1    <= wave_eff(waveSel1);
      sensor1Scan  <= sensor1Enable;
      settleDelay0 <= acq0;
      settleDelay1 <= acq1;
      calBusy      <= seqBusy;
      oscFast      <= oscSelect;
    end
  end
endmodule // tscr_config_regs

// File: bench/tscr_config_regs_assertions.sv
// Port checker for the configuration register bank.
// Assumes one clock, the synchronous reset srst, binding to the top.
`timescale 1ns/1ns
module tscr_config_regs_assertions #(
  parameter PULSE_CYCLES = 20
) (
  input wire        clock,
  input wire        srst,
  input wire        regWrite,
  input wire        regRead,
  input wire [7:0]  regAddr,
  input wire [7:0]  regWrData,
  input wire [7:0]  regRdData,
  input wire [1:0]  buttonDetect,
  input wire [1:0]  proxDetect,
  input wire        newData,
  input wire [15:0] idleTimeoutMs,
  input wire        detectOutN,
  input wire [1:0]  waveform0,
  input wire        sensor1Scan,
  input wire        oscFast,
  input wire        idle,
  input wire        scanStrobe
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);

  // Cycles since the last pulse request or detection. It saturates, so a
  // long quiet spell cannot wrap round and hide a stuck pin.
  reg [31:0] quietCnt;
  always @(posedge clock) begin
    if (srst || newData || (|buttonDetect) || (|proxDetect)) begin
      quietCnt <= 32'h0;
    end else if (quietCnt < PULSE_CYCLES + 4) begin
      quietCnt <= quietCnt + 32'h1;
    end
  end

  // A written control bit reaches its output two cycles later.
  property p_copy(a, out);
    regWrite && regAddr == a |-> ##2 out == $past(regWrData[0], 2);
  endproperty

  outctl_unused_a:
    assert property (regRead && regAddr == 8'h02 |=> regRdData[7:4] == 4'h0)
    else $error("Output control upper bits read nonzero.");
  cal_unused_a:
    assert property (regRead && (regAddr == 8'h03 || regAddr == 8'h04)
      |=> regRdData[5:2] == 4'h0)
    else $error("Calibration control middle bits read nonzero.");
  acq_unused_a:
    assert property (regRead && (regAddr == 8'h05 || regAddr == 8'h06)
      |=> regRdData[7:5] == 3'h0)
    else $error("Settle delay upper bits read nonzero.");
  lowpwr_unused_a:
    assert property (regRead && regAddr == 8'h07 |=> regRdData[7:6] == 2'h0)
    else $error("Low power upper bits read nonzero.");
  wave_map_a:
    assert property (regWrite && regAddr == 8'h03 && regWrData[7:6] == 2'b11
      |-> ##[1:2] waveform0 == 2'b01)
    else $error("Reserved waveform code not mapped to double.");
  osc_follow_a:
    assert property (p_copy(8'h07, oscFast))
    else $error("Oscillator select did not follow the written bit.");
  s1scan_follow_a:
    assert property (p_copy(8'h04, sensor1Scan))
    else $error("Second sensor scan did not follow its enable.");
  pin_quiet_a:
    assert property (quietCnt > PULSE_CYCLES + 2 |-> detectOutN)
    else $error("Detect pin low with no detection and no pulse.");
  idle_detect_a:
    assert property (buttonDetect[0] && idleTimeoutMs != 16'h0
      |-> ##[1:3] !idle)
    else $error("Idle held while a detection is present.");

  cover property ($fell(detectOutN));
  cover property (idle && scanStrobe);
  cover property ($rose(sensor1Scan));
endmodule // tscr_config_regs_assertions

bind tscr_config_regs tscr_config_regs_assertions #(
  .PULSE_CYCLES(PULSE_CYCLES)
) chk (
  .clock(clock), .srst(srst), .regWrite(regWrite), .regRead(regRead),
  .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
  .buttonDetect(buttonDetect), .proxDetect(proxDetect),
  .newData(newData), .idleTimeoutMs(idleTimeoutMs),
  .detectOutN(detectOutN), .waveform0(waveform0),
  .sensor1Scan(sensor1Scan), .oscFast(oscFast), .idle(idle),
  .scanStrobe(scanStrobe)
);

// File: bench/tscr_host_model.sv
// Host side of the register port: byte writes and reads.
// Assumes the one-cycle strobes and one-cycle read latency of the port.
`timescale 1ns/1ns
module tscr_host_model (
  input  wire       clock,
  output reg        regWrite,
  output reg        regRead,
  output reg  [7:0] regAddr,
  output reg  [7:0] regWrData,
  input  wire [7:0] regRdData
);
  // Released lines show the inverse so stale values never look valid.
  initial begin
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
  end

  // A whole checked frame arrives here as one byte write.
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge clock);
      regWrite <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge clock);
      regWrite <= 1'b0;
      regAddr <= ~a;
      regWrData <= ~d;
    end
  endtask

  task rd(input [7:0] a, output logic [7:0] d);
    begin
      @(posedge clock);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge clock);
      regRead <= 1'b0;
      regAddr <= ~a;
      #1;
      d = regRdData;
    end
  endtask

  // Recalibration is asked for by clearing the calibrated bit.
  task recal(input [7:0] a);
    logic [7:0] d;
    begin
      rd(a, d);
      wr(a, d & 8'hfd);
    end
  endtask
endmodule // tscr_host_model

// File: bench/tscr_config_regs_test.sv
// Self-checking bench of the configuration register bank.
// Assumes the host model for register traffic and a 125 MHz clock.
`timescale 1ns/1ns
`include "tscr_regs.vh"
module tscr_config_regs_test;
  localparam P = 20;
  localparam [7:0] A_OUT = `TSCR_OFF_OUTCTL;
  localparam [7:0] A_CAL0 = `TSCR_OFF_CALCTL0;
  localparam [7:0] A_CAL1 = `TSCR_OFF_CALCTL1;
  localparam [7:0] A_ACQ0 = `TSCR_OFF_ACQ0;
  localparam [7:0] A_ACQ1 = `TSCR_OFF_ACQ1;
  localparam [7:0] A_LOW = `TSCR_OFF_LOWPWR;
  reg        clock;
  reg        srst;
  wire       regWrite;
  wire       regRead;
  wire [7:0] regAddr;
  wire [7:0] regWrData;
  wire [7:0] regRdData;
  reg  [1:0] buttonDetect;
  reg  [1:0] proxDetect;
  reg        newData;
  reg        envChange;
  reg  [1:0] calSettled;
  wire       detectOutN;
  wire [1:0] waveform0;
  wire [1:0] waveform1;
  wire       sensor1Scan;
  wire [1:0] calBusy;
  wire       oscFast;
  wire       idle;
  wire       scanStrobe;
  wire [4:0] settleDelay0;
  wire [4:0] settleDelay1;
  integer    n_errors;
  integer    total_checks;
  logic [7:0] d;
  integer    i;
  integer    j;
  integer    n;

  tscr_host_model host (.clock(clock), .regWrite(regWrite),
    .regRead(regRead), .regAddr(regAddr), .regWrData(regWrData),
    .regRdData(regRdData));
  tscr_config_regs #(.PULSE_CYCLES(P), .SETTLE_CYCLES(2)) DUT (
    .clock(clock), .srst(srst), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
    .buttonDetect(buttonDetect), .proxDetect(proxDetect),
    .newData(newData), .envChange(envChange), .calSettled(calSettled),
    .idleTimeoutMs(16'h0001), .detectOutN(detectOutN),
    .waveform0(waveform0), .waveform1(waveform1),
    .sensor1Scan(sensor1Scan), .settleDelay0(settleDelay0),
    .settleDelay1(settleDelay1),
    .calBusy(calBusy), .oscFast(oscFast), .idle(idle),
    .scanStrobe(scanStrobe));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // -----------------------------------------------------------------
  // Shared tasks
  // -----------------------------------------------------------------
  task check(input string what, input logic [7:0] seen, exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
    end
  endtask

  task report_and_stop;
    begin
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
        $display("Test passed");
      end else begin
        $display("Test failed");
      end
      $finish;
    end
  endtask

  // Waits settle after the last edge so outputs are read once they land.
  task tick(input integer c);
    begin
      repeat (c) @(posedge clock);
      #1;
    end
  endtask

  // A hang counts as a mismatch and closes the run.
  task wait_cal;
    begin
      n = 0;
      tick(3);
      while (calBusy !== 2'b00 && n < 2000) begin
        tick(1);
        n = n + 1;
      end
      if (n == 2000) begin
        n_errors = n_errors + 1;
        report_and_stop;
      end
    end
  endtask

  // Cycles from the current scan strobe to the next one.
  task gap;
    begin
      n = 1;
      tick(1);
      while (scanStrobe !== 1'b1 && n < 1000) begin
        tick(1);
        n = n + 1;
      end
      if (n == 1000) begin
        n_errors = n_errors + 1;
        report_and_stop;
      end
    end
  endtask

  // -----------------------------------------------------------------
  // Scenarios
  // -----------------------------------------------------------------
  task s_reset_cal;
    begin
      host.rd(A_OUT, d);
      check("outctl", d, 8'h03);
      host.rd(A_LOW, d);
      check("lowpower", d, 8'h03);
      check("oscFast", oscFast, 8'h01);
      wait_cal;
      host.rd(A_CAL1, d);
      check("cal1", d, 8'h03);
      host.rd(A_ACQ1, d);
      check("acq1", d, 8'h1f);
      check("delay1", settleDelay1, 8'h1f);
      @(posedge clock) calSettled <= 2'b01;
      host.recal(A_CAL0);
      wait_cal;
      host.rd(A_ACQ0, d);
      check("acq0", d, 8'h00);
      check("delay0", settleDelay0, 8'h00);
      host.rd(A_CAL0, d);
      check("cal0", d, 8'h02);
    end
  endtask

  task s_wave;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        host.wr(A_CAL0, {i[1:0], 6'h02});
        host.wr(A_CAL1, {i[1:0], 6'h03});
        tick(2);
        check("wave0", waveform0, (i == 3) ? 8'h01 : i[7:0]);
        check("wave1", waveform1, (i == 3) ? 8'h01 : i[7:0]);
      end
    end
  endtask

  // Each enable bit against each detection source, one at a time.
  task s_pin;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        host.wr(A_OUT, 8'h01 << i);
        for (j = 0; j < 4; j = j + 1) begin
          @(posedge clock) {proxDetect, buttonDetect} <= 4'h1 << j;
          tick(2);
          check("pin", detectOutN, (i == j) ? 8'h00 : 8'h01);
        end
      end
      host.wr(A_OUT, 8'hff);
      @(posedge clock) {proxDetect, buttonDetect} <= 4'h0;
      tick(2);
      check("pin", detectOutN, 8'h01);
      host.rd(A_OUT, d);
      check("outctl", d, 8'h0f);
      host.wr(A_OUT, 8'h02);
      host.wr(A_CAL1, 8'h02);
      @(posedge clock) buttonDetect <= 2'b10;
      tick(2);
      check("scan1", sensor1Scan, 8'h00);
      check("pin", detectOutN, 8'h01);
      host.wr(A_CAL1, 8'h03);
      tick(2);
      check("scan1", sensor1Scan, 8'h01);
      check("pin", detectOutN, 8'h00);
      @(posedge clock) buttonDetect <= 2'b00;
    end
  endtask

  task s_pulse;
    begin
      host.wr(A_OUT, 8'h00);
      tick(2);
      check("pin", detectOutN, 8'h01);
      @(posedge clock) newData <= 1'b1;
      @(posedge clock) newData <= 1'b0;
      #1;
      n = 0;
      while (detectOutN === 1'b0 && n < 200) begin
        tick(1);
        n = n + 1;
      end
      check("pulse", n[7:0], P + 1);
    end
  endtask

  // Strobe spacing while idle, then while a detection is present.
  task s_sleep;
    reg [4:0] code [0:4];
    reg [7:0] ms [0:4];
    begin
      code = '{5'd0, 5'd1, 5'd3, 5'd19, 5'd31};
      ms = '{8'd1, 8'd2, 8'd8, 8'd1, 8'd1};
      for (i = 0; i < 5; i = i + 1) begin
        host.wr(A_LOW, {2'b00, code[i], 1'b0});
        gap;
        gap;
        gap;
        check("idle", idle, 8'h01);
        check("gap", n, ms[i] * P);
      end
      @(posedge clock) envChange <= 1'b1;
      @(posedge clock) envChange <= 1'b0;
      #1;
      check("idle", idle, 8'h00);
      check("oscFast", oscFast, 8'h00);
      host.wr(A_LOW, 8'h06);
      @(posedge clock) buttonDetect <= 2'b01;
      gap;
      gap;
      check("idle", idle, 8'h00);
      check("gap", n, P);
      @(posedge clock) buttonDetect <= 2'b00;
    end
  endtask

  task s_factory;
    begin
      host.wr(A_OUT, 8'h0f);
      host.wr(8'h00, 8'h12);
      host.rd(A_OUT, d);
      check("outctl", d, 8'h0f);
      @(posedge clock) calSettled <= 2'b00;
      host.wr(8'h00, 8'hff);
      tick(3);
      check("busy", calBusy, 8'h03);
      host.rd(A_LOW, d);
      check("lowpower", d, 8'h03);
      host.rd(A_OUT, d);
      check("outctl", d, 8'h03);
      wait_cal;
      host.rd(A_CAL0, d);
      check("cal0", d, 8'h02);
    end
  endtask

  initial begin
    n_errors = 0;
    total_checks = 0;
    srst = 1'b1;
    buttonDetect = 2'b00;
    proxDetect = 2'b00;
    newData = 1'b0;
    envChange = 1'b0;
    calSettled = 2'b00;
    repeat (12) @(posedge clock);
    srst <= 1'b0;
    s_reset_cal;
    s_wave;
    s_pin;
    s_pulse;
    s_sleep;
    s_factory;
    report_and_stop;
  end
endmodule // tscr_config_regs_test
